/* File: bss_pkg.sv */
// package: register map, field layout, reset values and timing for the slave window block
`default_nettype none
package bss_pkg;

  // ------------------------------------------------------------
  // register map and reset values
  // ------------------------------------------------------------
  localparam logic [11:0] DMA_STATUS_OFS  = 12'h04BF;
  localparam logic [11:0] SLV_WIN0_OFS    = 12'h04C3;
  localparam logic [7:0]  DMA_STATUS_RST  = 8'h60;
  localparam logic [7:0]  SLV_WIN0_RST    = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ST_WPOST   = 7;
  localparam int ST_BERR    = 4;
  localparam int ST_LFAULT  = 3;
  localparam int ST_DMABERR = 2;
  localparam int ST_DMALF   = 1;
  localparam int ST_BLOCK   = 0;
  localparam logic [7:0] ST_FIXED_MASK = 8'h60;  // unused bits read as after reset
  localparam int CR_TIMER   = 6;                 // bits 7..6
  localparam int CR_SUPER   = 5;
  localparam int CR_D32     = 4;
  localparam int CR_SPACE   = 2;                 // bits 3..2
  localparam int CR_MODE    = 0;                 // bits 1..0
  localparam int AM_SUPER_BIT = 2;

  // ------------------------------------------------------------
  // mode encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TMR_OFF = 2'b00, TMR_50HZ = 2'b01, TMR_1000HZ = 2'b10, TMR_100HZ = 2'b11
  } bss_timer_e;
  typedef enum logic [1:0] {
    SPC_A32 = 2'b00, SPC_A24 = 2'b01, SPC_A16 = 2'b10, SPC_USER = 2'b11
  } bss_space_e;
  typedef enum logic [1:0] {
    LTM_NONE = 2'b00, LTM_EMUL = 2'b01, LTM_ACCEL = 2'b10, LTM_RSVD = 2'b11
  } bss_xfer_e;
  // upper three address modifier bits per standard space
  localparam logic [2:0] AM_HI_A32 = 3'h1;
  localparam logic [2:0] AM_HI_A24 = 3'h7;
  localparam logic [2:0] AM_HI_A16 = 3'h5;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;
  localparam int RATE_50_HZ  = 50;
  localparam int RATE_100_HZ = 100;
  localparam int RATE_1K_HZ  = 1000;
  localparam int DIV_50      = CLK_HZ / RATE_50_HZ;
  localparam int DIV_100     = CLK_HZ / RATE_100_HZ;
  localparam int DIV_1K      = CLK_HZ / RATE_1K_HZ;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       req;     // one-cycle request pulse
    logic [5:0] am;      // address modifier
    logic       block;   // block transfer
    logic       d32;     // 32-bit data
  } bss_slave_req_s;
  typedef struct packed {
    logic ack;           // one-cycle accept pulse
    logic berr;          // one-cycle bus error pulse
  } bss_slave_rsp_s;

endpackage
`default_nettype wire

/* File: bss_slave_window.sv */
// register bank: DMA transfer status and slave window 0 control with their effects
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - status register resets to hex 60
// - write-post info bit always reads clear
// - status bit 4 mirrors backplane fault flag
// - status bit 3 mirrors local fault, clear
// - DMA backplane error sticky until software clears
// - DMA local fault bit never sets here
// - block bit clears when local DMA completes
// - window control register resets to zero
// - timer field picks off/50/1000/100 Hz
// - timer serviced only when irq2 enabled
// - supervisory bit rejects non-supervisory accesses
// - D32 bit gates 32-bit slave accesses
// - space field picks A32/A24/A16/user codes
// - mode 00 rejects incoming block transfers
// - mode 01 emulation unsupported, not used
// - mode 10 holds local strobe whole block
// - backplane fault flag sticky until cleared
// - user space compares source register code
module bss_slave_window #(
  parameter int DIV50  = bss_pkg::DIV_50,
  parameter int DIV100 = bss_pkg::DIV_100,
  parameter int DIV1K  = bss_pkg::DIV_1K
) (
  input  wire logic                    core_clk,          // 50 MHz clock
  input  wire logic                    reset,             // async, active high
  input  wire logic [11:0]             ioAddr,            // byte I/O address
  input  wire logic                    ioRd,              // read strobe
  input  wire logic                    ioWr,              // write strobe
  input  wire logic [7:0]              ioWrData,          // write byte
  output logic      [7:0]              ioRdData,          // read byte, next cycle
  input  wire logic                    berrPin,           // backplane bus error, async
  input  wire logic                    faultFlagClear,    // clears bus fault flag
  input  wire logic                    dmaActive,         // local DMA running
  input  wire logic                    blockStart,        // interleaved block begins
  input  wire logic                    dmaDone,           // local DMA completes
  input  wire logic                    irq2Enable,        // local_irq2_control enable
  input  wire logic [5:0]              amSource,          // am_source_register code
  input  wire bss_pkg::bss_slave_req_s slvReq,            // window 0 access
  output bss_pkg::bss_slave_rsp_s      slvRsp,            // accept or bus error
  output logic                         busFaultFlag,      // backplane fault flag
  output logic                         localIrqLine2,     // periodic timer pulse
  output logic                         timerService,      // serviced timer event
  output logic                         localAddrStrobe    // held over block
);

  // ------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------
  logic berrMeta_reg, berrSync_reg;
  logic berrMeta_next, berrSync_next;

  // backplane pin, two flops before use
  always_comb begin
    berrMeta_next = berrPin;
    berrSync_next = berrMeta_reg;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      berrMeta_reg <= 1'b0;
      berrSync_reg <= 1'b0;
    end else begin
      berrMeta_reg <= berrMeta_next;
      berrSync_reg <= berrSync_next;
    end
  end

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wrStatus, wrCtrl;
  assign wrStatus = ioWr && hit(ioAddr, bss_pkg::DMA_STATUS_OFS);
  assign wrCtrl   = ioWr && hit(ioAddr, bss_pkg::SLV_WIN0_OFS);

  // ------------------------------------------------------------
  // status and control registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_reg, ctrl_next;
  logic       faultFlag_reg, faultFlag_next;
  logic       dmaBerr_reg, dmaBerr_next;
  logic       block_reg, block_next;
  logic [7:0] status;
  logic [7:0] rdData_reg, rdData_next;

  // sticky flags: a set in the cycle of a clear wins, so no event is lost
  always_comb begin
    ctrl_next      = ctrl_reg;
    faultFlag_next = faultFlag_reg;
    dmaBerr_next   = dmaBerr_reg;
    block_next     = block_reg;
    if (wrCtrl) begin
      ctrl_next = ioWrData;
    end
    if (faultFlagClear) begin
      faultFlag_next = 1'b0;
    end
    if (berrSync_reg) begin
      faultFlag_next = 1'b1;
    end
    if (wrStatus && !ioWrData[bss_pkg::ST_DMABERR]) begin
      dmaBerr_next = 1'b0;
    end
    if (berrSync_reg && dmaActive) begin
      dmaBerr_next = 1'b1;
    end
    if (dmaDone) begin
      block_next = 1'b0;
    end
    if (blockStart) begin
      block_next = 1'b1;
    end
  end

  always_comb begin
    status                        = bss_pkg::ST_FIXED_MASK;
    status[bss_pkg::ST_WPOST]     = 1'b0;
    status[bss_pkg::ST_BERR]      = faultFlag_reg;
    status[bss_pkg::ST_LFAULT]    = 1'b0;
    status[bss_pkg::ST_DMABERR]   = dmaBerr_reg;
    status[bss_pkg::ST_DMALF]     = 1'b0;
    status[bss_pkg::ST_BLOCK]     = block_reg;
  end

  // read data registered; unmapped addresses read zero
  always_comb begin
    rdData_next = rdData_reg;
    if (ioRd) begin
      if (hit(ioAddr, bss_pkg::DMA_STATUS_OFS)) begin
        rdData_next = status;
      end else if (hit(ioAddr, bss_pkg::SLV_WIN0_OFS)) begin
        rdData_next = ctrl_reg;
      end else begin
        rdData_next = bss_pkg::UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg      <= bss_pkg::SLV_WIN0_RST;
      faultFlag_reg <= 1'b0;
      dmaBerr_reg   <= 1'b0;
      block_reg     <= 1'b0;
      rdData_reg    <= 8'h00;
    end else begin
      ctrl_reg      <= ctrl_next;
      faultFlag_reg <= faultFlag_next;
      dmaBerr_reg   <= dmaBerr_next;
      block_reg     <= block_next;
      rdData_reg    <= rdData_next;
    end
  end

  assign ioRdData     = rdData_reg;
  assign busFaultFlag = faultFlag_reg;

  // ------------------------------------------------------------
  // periodic timer
  // ------------------------------------------------------------
  bss_pkg::bss_timer_e timerMode;
  assign timerMode = bss_pkg::bss_timer_e'(ctrl_reg[bss_pkg::CR_TIMER +: 2]);

  logic [31:0] divCnt_reg, divCnt_next;
  logic [1:0]  lastMode_reg, lastMode_next;
  logic        tick_reg, tick_next;
  logic        service_reg, service_next;
  logic [31:0] divTop;

  always_comb begin
    unique case (timerMode)
      bss_pkg::TMR_50HZ:   divTop = 32'(DIV50 - 1);
      bss_pkg::TMR_1000HZ: divTop = 32'(DIV1K - 1);
      bss_pkg::TMR_100HZ:  divTop = 32'(DIV100 - 1);
      bss_pkg::TMR_OFF:    divTop = 32'h0000_0000;
    endcase
  end

  // a rate change restarts the period so the first pulse is a full one
  always_comb begin
    lastMode_next = ctrl_reg[bss_pkg::CR_TIMER +: 2];
    tick_next     = 1'b0;
    divCnt_next   = divCnt_reg + 32'h0000_0001;
    if (timerMode == bss_pkg::TMR_OFF || lastMode_reg != ctrl_reg[bss_pkg::CR_TIMER +: 2]) begin
      divCnt_next = 32'h0000_0000;
    end else if (divCnt_reg >= divTop) begin
      divCnt_next = 32'h0000_0000;
      tick_next   = 1'b1;
    end
    service_next = tick_next && irq2Enable;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      divCnt_reg   <= 32'h0000_0000;
      lastMode_reg <= 2'b00;
      tick_reg     <= 1'b0;
      service_reg  <= 1'b0;
    end else begin
      divCnt_reg   <= divCnt_next;
      lastMode_reg <= lastMode_next;
      tick_reg     <= tick_next;
      service_reg  <= service_next;
    end
  end

  assign localIrqLine2 = tick_reg;
  assign timerService  = service_reg;

  // ------------------------------------------------------------
  // slave window 0 qualification
  // ------------------------------------------------------------
  bss_pkg::bss_space_e space;
  bss_pkg::bss_xfer_e  xferMode;
  assign space    = bss_pkg::bss_space_e'(ctrl_reg[bss_pkg::CR_SPACE +: 2]);
  assign xferMode = bss_pkg::bss_xfer_e'(ctrl_reg[bss_pkg::CR_MODE +: 2]);

  logic spaceOk, reject;
  bss_pkg::bss_slave_rsp_s rsp_reg, rsp_next;
  logic strobe_reg, strobe_next;

  always_comb begin
    unique case (space)
      bss_pkg::SPC_A32:  spaceOk = slvReq.am[5:3] == bss_pkg::AM_HI_A32;
      bss_pkg::SPC_A24:  spaceOk = slvReq.am[5:3] == bss_pkg::AM_HI_A24;
      bss_pkg::SPC_A16:  spaceOk = slvReq.am[5:3] == bss_pkg::AM_HI_A16;
      bss_pkg::SPC_USER: spaceOk = slvReq.am == amSource;
    endcase
  end

  // only accelerated mode carries block transfers; emulation is not built
  always_comb begin
    reject = !spaceOk;
    if (ctrl_reg[bss_pkg::CR_SUPER] && !slvReq.am[bss_pkg::AM_SUPER_BIT]) begin
      reject = 1'b1;
    end
    if (slvReq.d32 && !ctrl_reg[bss_pkg::CR_D32]) begin
      reject = 1'b1;
    end
    if (slvReq.block && xferMode != bss_pkg::LTM_ACCEL) begin
      reject = 1'b1;
    end
    rsp_next.ack  = slvReq.req && !reject;
    rsp_next.berr = slvReq.req && reject;
  end

  always_comb begin
    strobe_next = (ctrl_next[bss_pkg::CR_MODE +: 2] == bss_pkg::LTM_ACCEL) && block_next;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rsp_reg    <= '0;
      strobe_reg <= 1'b0;
    end else begin
      rsp_reg    <= rsp_next;
      strobe_reg <= strobe_next;
    end
  end

  assign slvRsp          = rsp_reg;
  assign localAddrStrobe = strobe_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_berrSeen;
    berrSync_reg && !faultFlagClear;
  endsequence

  a_status_fixed_bits: assert property (
    status[7:5] == 3'b011 && status[bss_pkg::ST_LFAULT] == 1'b0)
    else $error("status fixed bits wrong");
  a_fault_mirror: assert property (
    ##1 ioRd && hit(ioAddr, bss_pkg::DMA_STATUS_OFS) |=> ioRdData[4] == $past(faultFlag_reg))
    else $error("fault mirror mismatch");
  a_fault_sticky: assert property (
    s_berrSeen |=> busFaultFlag ##1 (busFaultFlag || $past(faultFlagClear)))
    else $error("fault flag not sticky");
  a_dma_berr_set: assert property (
    berrSync_reg && dmaActive |=> dmaBerr_reg)
    else $error("dma error not set");
  a_block_clear: assert property (
    dmaDone && !blockStart |=> !block_reg)
    else $error("block bit not cleared");
  a_ctrl_write: assert property (
    wrCtrl ##1 !wrCtrl ##1 ioRd && hit(ioAddr, bss_pkg::SLV_WIN0_OFS)
      |=> ioRdData == $past(ioWrData, 3))
    else $error("control readback wrong");
  a_timer_off_quiet: assert property (
    (timerMode == bss_pkg::TMR_OFF) [*2] |-> !localIrqLine2)
    else $error("timer pulse while off");
  a_service_gate: assert property (
    timerService |-> localIrqLine2 && $past(irq2Enable))
    else $error("service without enable");
  a_super_reject: assert property (
    slvReq.req && ctrl_reg[bss_pkg::CR_SUPER] && !slvReq.am[2] |=> slvRsp.berr && !slvRsp.ack)
    else $error("non supervisory accepted");
  a_block_reject: assert property (
    slvReq.req && slvReq.block && xferMode == bss_pkg::LTM_NONE |=> slvRsp.berr)
    else $error("block accepted in mode 00");
  a_strobe_hold: assert property (
    localAddrStrobe == (block_reg && xferMode == bss_pkg::LTM_ACCEL))
    else $error("strobe outside block");

endmodule
`default_nettype wire

/* File: bss_slave_window_tb.sv */
// self-checking bench for the status and slave window 0 register block
`timescale 1ns/10ps
`default_nettype none
module bss_slave_window_tb;
  logic                    coreClk;
  logic                    reset;
  logic [11:0]             ioAddr;
  logic                    ioRd;
  logic                    ioWr;
  logic [7:0]              ioWrData;
  logic [7:0]              ioRdData;
  logic                    berrPin;
  logic                    faultFlagClear;
  logic                    dmaActive;
  logic                    blockStart;
  logic                    dmaDone;
  logic                    irq2Enable;
  logic [5:0]              amSource;
  bss_pkg::bss_slave_req_s slvReq;
  bss_pkg::bss_slave_rsp_s slvRsp;
  logic                    busFaultFlag;
  logic                    localIrqLine2;
  logic                    timerService;
  logic                    localAddrStrobe;
  int                      miscompares;
  int                      samplesChecked;
  localparam logic [11:0]  ST = bss_pkg::DMA_STATUS_OFS;
  localparam logic [11:0]  CR = bss_pkg::SLV_WIN0_OFS;

  // ------------------------------------------------------------
  // clock, design and far side
  // ------------------------------------------------------------
  // short dividers keep the timer periods within a brief run
  initial coreClk = 1'b0;
  always #10 coreClk = ~coreClk;
  bss_slave_window #(.DIV50(20), .DIV100(10), .DIV1K(4)) dut (
    .core_clk(coreClk), .reset(reset), .ioAddr(ioAddr), .ioRd(ioRd), .ioWr(ioWr),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .berrPin(berrPin),
    .faultFlagClear(faultFlagClear), .dmaActive(dmaActive), .blockStart(blockStart),
    .dmaDone(dmaDone), .irq2Enable(irq2Enable), .amSource(amSource), .slvReq(slvReq),
    .slvRsp(slvRsp), .busFaultFlag(busFaultFlag), .localIrqLine2(localIrqLine2),
    .timerService(timerService), .localAddrStrobe(localAddrStrobe));
  bss_vme_partner partner (.core_clk(coreClk), .slvRsp(slvRsp), .slvReq(slvReq),
                           .berrPin(berrPin));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic completeRun();
    $display("comparisons %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // a write takes effect at the taking edge
  task automatic regWr(input logic [11:0] a, input logic [7:0] d);
    @(negedge coreClk);
    ioAddr   = a;
    ioWrData = d;
    ioWr     = 1'b1;
    @(negedge coreClk);
    ioWr = 1'b0;
  endtask

  // read data is registered, so it is judged one cycle after the strobe
  task automatic regRd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(negedge coreClk);
    ioAddr = a;
    ioRd   = 1'b1;
    @(negedge coreClk);
    ioRd = 1'b0;
    check(ioRdData, exp, what);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic scnResetValues();
    regRd(ST, 8'h60, "status reset");
    // unmapped read follows a nonzero read so a stale byte would show
    regRd(12'h04C0, 8'h00, "unmapped read");
    regRd(CR, 8'h00, "control reset");
  endtask

  // table of control, modifier, block, d32 and expected refusal
  task automatic scnWindow();
    logic [16:0]              tbl [12];
    bss_pkg::bss_slave_rsp_s  rsp;
    tbl = '{{8'h00, 6'h0D, 3'b000}, {8'h00, 6'h0D, 3'b011}, {8'h00, 6'h0D, 3'b101},
            {8'h12, 6'h0D, 3'b110}, {8'h01, 6'h0D, 3'b101}, {8'h20, 6'h09, 3'b001},
            {8'h20, 6'h0D, 3'b000}, {8'h04, 6'h3D, 3'b000}, {8'h04, 6'h0D, 3'b001},
            {8'h08, 6'h2D, 3'b000}, {8'h0C, 6'h15, 3'b000}, {8'h0C, 6'h0D, 3'b001}};
    amSource = 6'h15;
    for (int i = 0; i < 12; i++) begin
      regWr(CR, tbl[i][16:9]);
      regRd(CR, tbl[i][16:9], "control readback");
      partner.access(tbl[i][8:3], tbl[i][2], tbl[i][1], rsp);
      check({6'h00, rsp.berr, rsp.ack}, {6'h00, tbl[i][0], ~tbl[i][0]}, "window answer");
    end
    // leave window 0 in the extended space
    regWr(CR, 8'h00);
  endtask

  task automatic scnFault();
    dmaActive = 1'b1;
    partner.busError(2);
    repeat (4) @(negedge coreClk);
    dmaActive = 1'b0;
    repeat (6) @(negedge coreClk);
    check({7'h00, busFaultFlag}, 8'h01, "fault flag sticky");
    regRd(ST, 8'h74, "status after error in transfer");
    faultFlagClear = 1'b1;
    @(negedge coreClk);
    faultFlagClear = 1'b0;
    regRd(ST, 8'h64, "status after flag clear");
    regWr(ST, 8'hFB);
    regRd(ST, 8'h60, "status after software clear");
    partner.busError(2);
    repeat (4) @(negedge coreClk);
    regRd(ST, 8'h70, "error outside transfer");
    faultFlagClear = 1'b1;
    @(negedge coreClk);
    faultFlagClear = 1'b0;
  endtask

  // software selects the accelerated mode before a block
  task automatic scnBlock();
    regWr(CR, 8'h02);
    @(negedge coreClk);
    blockStart = 1'b1;
    @(negedge coreClk);
    blockStart = 1'b0;
    repeat (5) @(negedge coreClk);
    regRd(ST, 8'h61, "block in progress");
    check({7'h00, localAddrStrobe}, 8'h01, "strobe held");
    dmaDone = 1'b1;
    @(negedge coreClk);
    dmaDone = 1'b0;
    regRd(ST, 8'h60, "block completed");
    check({7'h00, localAddrStrobe}, 8'h00, "strobe released");
    regWr(CR, 8'h00);
  endtask

  // measure the gap between two pulses for every timer code
  task automatic scnTimer();
    int first;
    int gap;
    int expGap [4];
    expGap = '{0, 20, 4, 10};
    for (int c = 0; c < 4; c++) begin
      irq2Enable = c[0];
      regWr(CR, {c[1:0], 6'h00});
      first = -1;
      gap   = 0;
      for (int n = 0; n < 60 && gap == 0; n++) begin
        @(negedge coreClk);
        if (localIrqLine2 === 1'b1) begin
          check({7'h00, timerService}, {7'h00, irq2Enable}, "timer service");
          if (first >= 0) begin
            gap = n - first;
          end
          first = n;
        end
      end
      check(8'(gap), 8'(expGap[c]), "timer period");
      // a restarted divider puts the second pulse two full periods after the write
      check(8'(first), 8'(c == 0 ? -1 : 2 * expGap[c]), "timer restart");
    end
    irq2Enable = 1'b0;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    miscompares    = 0;
    samplesChecked = 0;
    reset          = 1'b1;
    ioAddr         = 12'h0000;
    ioRd           = 1'b0;
    ioWr           = 1'b0;
    ioWrData       = 8'h00;
    faultFlagClear = 1'b0;
    dmaActive      = 1'b0;
    blockStart     = 1'b0;
    dmaDone        = 1'b0;
    irq2Enable     = 1'b0;
    amSource       = 6'h00;
    repeat (10) @(negedge coreClk);
    reset = 1'b0;
    scnResetValues();
    scnWindow();
    scnFault();
    scnBlock();
    scnTimer();
    completeRun();
  end
endmodule
`default_nettype wire

/* File: bss_vme_partner.sv */
// far-side model: a backplane master issuing window 0 cycles and bus errors
`timescale 1ns/10ps
`default_nettype none
module bss_vme_partner (
  input  wire logic                    core_clk,  // system clock
  input  wire bss_pkg::bss_slave_rsp_s slvRsp,    // device answer
  output bss_pkg::bss_slave_req_s      slvReq,    // window 0 cycle
  output logic                         berrPin    // backplane bus error, idle low
);
  // ------------------------------------------------------------
  // idle state
  // ------------------------------------------------------------
  initial begin
    slvReq  = '0;
    berrPin = 1'b0;
  end

  // ------------------------------------------------------------
  // cycles
  // ------------------------------------------------------------
  // request stands for one taking edge; the answer is read in the following cycle
  // qualifiers are inverted after release so a stale value is never mistaken for a live one
  task automatic access(input logic [5:0] am, input logic blk, input logic d32,
                        output bss_pkg::bss_slave_rsp_s rsp);
    @(negedge core_clk);
    slvReq = '{req: 1'b1, am: am, block: blk, d32: d32};
    @(negedge core_clk);
    rsp    = slvRsp;
    slvReq = '{req: 1'b0, am: ~am, block: ~blk, d32: ~d32};
  endtask

  // hold the error line for a number of cycles
  task automatic busError(input int cycles);
    @(negedge core_clk);
    berrPin = 1'b1;
    repeat (cycles) @(negedge core_clk);
    berrPin = 1'b0;
  endtask
endmodule
`default_nettype wire
